/* common/acd_regs.svh */
// constants for the accumulator instruction decoder
// Function
// (RULE1) peripheral register access 20h-4Fh add_unsigned cycle
// (RULE2) external write two cycles, read one
// (RULE3) write next to external read takes three
// (RULE4) same single-access block conflict add_unsigned cycle
// (RULE5) magnitude op takes absolute value, clears carry
// (RULE6) add memory shifted by field or sixteen
// (RULE7) short immediate add of low byte
// (RULE8) long immediate add with shift, two cycles
// (RULE9) add buffer, optionally plus carry
// (RULE10) carry and unsigned add_unsigned skip sign extension
// (RULE11) add or load shifted by count register
// (RULE12) memory AND clears high; OR low only
// (RULE13) long immediate AND and OR, shifts
// (RULE14) negate and invert accumulator
// (RULE15) right shift by zero or sixteen
// (RULE16) right shift by count or field
// (RULE17) keep greater or lesser in buffer
// (RULE18) swap with buffer, copy into buffer
// (RULE19) three forms of accumulator load
// (RULE20) low load clears high half
// (RULE21) mapped register load and store
// (RULE22) one-bit rotates and shifts, single or pair
// (RULE23) bit seven selects direct or indirect
// (RULE24) high half bits 31-16, low 15-0
// (RULE25) store high or low half shifted
`ifndef ACD_REGS_SVH
`define ACD_REGS_SVH
`define ACD_PERIPH_LO 16'h0020
`define ACD_PERIPH_HI 16'h004F
`define ACD_EXT_WR_CYC 3'h2
`define ACD_EXT_WR_TURN_CYC 3'h3
`define ACD_EXT_RD_CYC 3'h1
`define ACD_BLOCK_BITS 11
`define ACD_IND_BIT 7
`define ACD_ACC_RST 32'h0000_0000
`endif

/* common/acd_pkg.sv */
// types for the accumulator instruction decoder
package acd_pkg;
  typedef enum logic [1:0] {
    ACD_FETCH = 2'b00,
    ACD_EXEC = 2'b01,
    ACD_WAIT = 2'b10,
    ACD_LONG = 2'b11
  } acd_state_t;
endpackage : acd_pkg

/* logic/acd_shifter.sv */
// shift helper for the accumulator operand path
`timescale 1ns/1ps
module acd_shifter (
  input wire logic [31:0] din,
  input wire logic [4:0] amt,
  input wire logic right,
  input wire logic arith,
  output logic [31:0] dout
);
  always_comb begin
    if (right) begin
      dout = arith ? 32'($signed(din) >>> amt) : (din >> amt);
    end else begin
      dout = din << amt;
    end
  end
endmodule : acd_shifter

/* logic/acd_decoder.sv */
// accumulator group decoder and executor
`include "acd_regs.svh"
`timescale 1ns/1ps
module acd_decoder import acd_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] dataPage,
  input wire logic [15:0] auxAddr,
  input wire logic [4:0] shiftCountRegister,
  input wire logic signExtMode,
  input wire logic externalAccess,
  input wire logic pipeBlockBusy,
  input wire logic [15:0] pipeBlockAddr,
  output logic instrReady,
  output logic [15:0] dataAddr,
  output logic dataRead,
  output logic dataWrite,
  output logic [15:0] dataOut,
  output logic [31:0] mainAccumulator,
  output logic [31:0] accumulatorBuffer,
  output logic carryFlag
);
  typedef struct packed {
    acd_state_t st;
    logic [15:0] op;
    logic [2:0] wait_;
    logic lastExtRead;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [15:0] dout;
    logic [31:0] acc;
    logic [31:0] bufWord;
    logic c;
    logic rdy;
  } acd_core_t;

  acd_core_t s_r, s_nxt;
  logic [31:0] shIn, shOut;
  logic [4:0] shAmt;
  logic shRight, shArith;
  logic [15:0] effAddr;
  logic [32:0] sum;
  logic [31:0] opnd;
  logic isMem, isWrite, periph;

  // -------------------------------------------------------------
  // operand shifter
  // -------------------------------------------------------------
  acd_shifter u_shift (
    .din(shIn),
    .amt(shAmt),
    .right(shRight),
    .arith(shArith),
    .dout(shOut)
  );

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  // (RULE23) direct or indirect address
  assign effAddr = instrWord[`ACD_IND_BIT] ? auxAddr : {dataPage[15:7], instrWord[6:0]};
  assign isMem = instrWord[15:12] == 4'h0 || instrWord[15:12] == 4'h1 || instrWord[15:12] == 4'h2
    || instrWord[15:8] == 8'h60 || instrWord[15:8] == 8'h61 || instrWord[15:8] == 8'h62
    || instrWord[15:8] == 8'h63 || instrWord[15:8] == 8'h69 || instrWord[15:8] == 8'h6A
    || instrWord[15:8] == 8'h6B || instrWord[15:8] == 8'h6D || instrWord[15:8] == 8'h6E
    || instrWord[15:11] == 5'b1001_0 || instrWord[15:11] == 5'b1001_1 || instrWord[15:8] == 8'h88;
  assign isWrite = instrWord[15:12] == 4'h9 || instrWord[15:8] == 8'h88;
  // (RULE1) peripheral window
  assign periph = effAddr >= `ACD_PERIPH_LO && effAddr <= `ACD_PERIPH_HI;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = 1'b0;
    s_nxt.wr = 1'b0;
    s_nxt.rdy = 1'b0;
    shIn = 32'h0000_0000;
    shAmt = 5'h00;
    shRight = 1'b0;
    shArith = 1'b0;
    sum = 33'h0_0000_0000;
    // (RULE10) sign extension per mode
    opnd = (signExtMode && s_r.op[15:8] != 8'h60 && s_r.op[15:8] != 8'h62)
      ? {{16{dataIn[15]}}, dataIn} : {16'h0000, dataIn};
    case (s_r.st)
      ACD_FETCH: begin
        s_nxt.rdy = 1'b1;
        if (instrValid && s_r.rdy) begin
          s_nxt.op = instrWord;
          s_nxt.addr = effAddr;
          s_nxt.rdy = 1'b0;
          s_nxt.st = ACD_EXEC;
          s_nxt.wait_ = 3'h0;
          if (isMem) begin
            s_nxt.rd = ~isWrite;
            s_nxt.wr = isWrite;
            // (RULE25) store half with 3-bit shift
            if (instrWord[15:12] == 4'h9) begin
              s_nxt.dout = instrWord[11] ? 16'((s_r.acc << instrWord[10:8]) >> 16)
                : 16'(s_r.acc << instrWord[10:8]);
            end else begin
              // (RULE21) mapped register store
              s_nxt.dout = s_r.acc[15:0];
            end
            // (RULE1) extra cycle for peripheral
            if (periph) begin
              s_nxt.wait_ = 3'h1;
            end
            // (RULE2) external cost
            if (externalAccess) begin
              // (RULE3) write beside read stretched
              s_nxt.wait_ = isWrite ? (s_r.lastExtRead ? `ACD_EXT_WR_TURN_CYC - 3'h1
                : `ACD_EXT_WR_CYC - 3'h1) : `ACD_EXT_RD_CYC - 3'h1;
            end
            // (RULE4) same 2K block conflict
            if (pipeBlockBusy && effAddr[15:`ACD_BLOCK_BITS] == pipeBlockAddr[15:`ACD_BLOCK_BITS]) begin
              s_nxt.wait_ = 3'(s_nxt.wait_ + 3'h1);
            end
            s_nxt.lastExtRead = externalAccess && !isWrite;
          end else begin
            s_nxt.lastExtRead = 1'b0;
          end
          if (instrWord[15:8] == 8'hBF && (instrWord[7:4] == 4'h8 || instrWord[7:4] == 4'h9
              || instrWord[7:4] == 4'hB || instrWord[7:4] == 4'hC)) begin
            s_nxt.st = ACD_LONG;
            s_nxt.rdy = 1'b1;
          end else if (instrWord[15:4] == 12'hBE8) begin
            s_nxt.st = ACD_LONG;
            s_nxt.rdy = 1'b1;
          end else if (s_nxt.wait_ != 3'h0) begin
            s_nxt.st = ACD_WAIT;
          end
        end
      end
      ACD_WAIT: begin
        s_nxt.wait_ = 3'(s_r.wait_ - 3'h1);
        if (s_r.wait_ == 3'h1) begin
          s_nxt.st = ACD_EXEC;
        end
      end
      ACD_LONG: begin
        // (RULE8) second word holds constant
        if (instrValid && s_r.rdy) begin
          s_nxt.dout = instrWord;
          s_nxt.st = ACD_EXEC;
        end else begin
          s_nxt.rdy = 1'b1;
        end
      end
      ACD_EXEC: begin
        s_nxt.st = ACD_FETCH;
        s_nxt.rdy = 1'b1;
        shIn = opnd;
        if (s_r.op[15:12] == 4'h1 || s_r.op[15:12] == 4'h2) begin
          // (RULE6) add shifted by field
          shAmt = {1'b0, s_r.op[11:8]};
          sum = s_r.op[15:12] == 4'h2 ? {1'b0, s_r.acc} + {1'b0, shOut} : {1'b0, shOut};
          if (s_r.op[15:12] == 4'h2) begin
            s_nxt.c = sum[32];
          end
          // (RULE19) load with shift
          s_nxt.acc = sum[31:0];
        end else if (s_r.op[15:8] == 8'h61 || s_r.op[15:8] == 8'h6A) begin
          // (RULE6) add shifted sixteen
          shAmt = 5'h10;
          sum = s_r.op[8] ? {1'b0, s_r.acc} + {1'b0, shOut} : {1'b0, shOut};
          s_nxt.acc = sum[31:0];
        end else if (s_r.op[15:8] == 8'h60 || s_r.op[15:8] == 8'h62) begin
          // (RULE10) unsigned add, optional carry
          sum = {1'b0, s_r.acc} + {17'h0_0000, dataIn} + {32'h0000_0000, s_r.op[9] ? 1'b0 : s_r.c};
          s_nxt.acc = sum[31:0];
          s_nxt.c = sum[32];
        end else if (s_r.op[15:8] == 8'h63 || s_r.op[15:8] == 8'h6B) begin
          // (RULE11) shift by count register
          shAmt = {1'b0, shiftCountRegister[3:0]};
          sum = s_r.op[15:8] == 8'h63 ? {1'b0, s_r.acc} + {1'b0, shOut} : {1'b0, shOut};
          s_nxt.acc = sum[31:0];
        end else if (s_r.op[15:8] == 8'h6E) begin
          // (RULE12) AND clears high
          s_nxt.acc = {16'h0000, s_r.acc[15:0] & dataIn};
        end else if (s_r.op[15:8] == 8'h6D) begin
          s_nxt.acc = {s_r.acc[31:16], s_r.acc[15:0] | dataIn};
        end else if (s_r.op[15:8] == 8'h69 || s_r.op[15:8] == 8'h08) begin
          // (RULE20) low load clears high
          // (RULE21) mapped register load
          s_nxt.acc = {16'h0000, dataIn};
        end else if (s_r.op[15:8] == 8'hB9) begin
          s_nxt.acc = {24'h00_0000, s_r.op[7:0]};
        end else if (s_r.op[15:8] == 8'hB8) begin
          // (RULE7) short immediate add
          sum = {1'b0, s_r.acc} + {25'h000_0000, s_r.op[7:0]};
          s_nxt.acc = sum[31:0];
          s_nxt.c = sum[32];
        end else if (s_r.op[15:8] == 8'hBF) begin
          // (RULE13) logic forms unsigned
          shIn = (signExtMode && s_r.op[7:4] != 4'hB && s_r.op[7:4] != 4'hC)
            ? {{16{s_r.dout[15]}}, s_r.dout} : {16'h0000, s_r.dout};
          shAmt = {1'b0, s_r.op[3:0]};
          shRight = s_r.op[7:4] == 4'hE;
          shArith = signExtMode;
          if (s_r.op[7:4] == 4'hE) begin
            // (RULE16) immediate barrel right
            shIn = s_r.acc;
            s_nxt.acc = shOut;
          end else if (s_r.op[7:4] == 4'h9) begin
            // (RULE8) long immediate add
            sum = {1'b0, s_r.acc} + {1'b0, shOut};
            s_nxt.acc = sum[31:0];
            s_nxt.c = sum[32];
          end else if (s_r.op[7:4] == 4'h8) begin
            // (RULE19) long immediate load
            s_nxt.acc = shOut;
          end else if (s_r.op[7:4] == 4'hB) begin
            // (RULE13) variable shift AND
            s_nxt.acc = s_r.acc & shOut;
          end else if (s_r.op[7:4] == 4'hC) begin
            s_nxt.acc = s_r.acc | shOut;
          end
        end else if (s_r.op[15:4] == 12'hBE8) begin
          // (RULE13) fixed sixteen AND/OR
          if (s_r.op[3:0] == 4'h1) begin
            s_nxt.acc = s_r.acc & {s_r.dout, 16'h0000};
          end else if (s_r.op[3:0] == 4'h2) begin
            s_nxt.acc = s_r.acc | {s_r.dout, 16'h0000};
          end
        end else if (s_r.op[15:8] == 8'hBE) begin
          shIn = s_r.acc;
          shRight = 1'b1;
          shArith = signExtMode;
          case (s_r.op[7:0])
            // (RULE5) magnitude, carry cleared
            8'h00: begin
              s_nxt.acc = s_r.acc[31] ? 32'(-s_r.acc) : s_r.acc;
              s_nxt.c = 1'b0;
            end
            // (RULE14) invert and negate
            8'h01: s_nxt.acc = ~s_r.acc;
            8'h02: s_nxt.acc = 32'(-s_r.acc);
            // (RULE22) one-bit moves
            8'h09: begin
              s_nxt.acc = {s_r.acc[30:0], 1'b0};
              s_nxt.c = s_r.acc[31];
            end
            8'h0A: begin
              s_nxt.acc = {signExtMode & s_r.acc[31], s_r.acc[31:1]};
              s_nxt.c = s_r.acc[0];
            end
            8'h0C: begin
              s_nxt.acc = {s_r.acc[30:0], s_r.c};
              s_nxt.c = s_r.acc[31];
            end
            8'h0D: begin
              s_nxt.acc = {s_r.c, s_r.acc[31:1]};
              s_nxt.c = s_r.acc[0];
            end
            8'h14: begin
              {s_nxt.c, s_nxt.acc, s_nxt.bufWord} = {s_r.acc, s_r.bufWord, s_r.c};
            end
            8'h15: begin
              {s_nxt.acc, s_nxt.bufWord, s_nxt.c} = {s_r.c, s_r.acc, s_r.bufWord};
            end
            8'h16: begin
              {s_nxt.c, s_nxt.acc, s_nxt.bufWord} = {s_r.acc, s_r.bufWord, 1'b0};
            end
            8'h17: begin
              {s_nxt.acc, s_nxt.bufWord, s_nxt.c} = {signExtMode & s_r.acc[31], s_r.acc, s_r.bufWord};
            end
            // (RULE9) buffer add with optional carry
            8'h10, 8'h11: begin
              sum = {1'b0, s_r.acc} + {1'b0, s_r.bufWord} + {32'h0000_0000, s_r.op[0] & s_r.c};
              s_nxt.acc = sum[31:0];
              s_nxt.c = sum[32];
            end
            // (RULE17) keep greater or lesser
            8'h1B: if ($signed(s_r.acc) > $signed(s_r.bufWord)) s_nxt.bufWord = s_r.acc;
            8'h1C: if ($signed(s_r.acc) < $signed(s_r.bufWord)) s_nxt.bufWord = s_r.acc;
            // (RULE18) swap and copies
            8'h1D: begin
              s_nxt.acc = s_r.bufWord;
              s_nxt.bufWord = s_r.acc;
            end
            8'h1E, 8'h1F: s_nxt.bufWord = s_r.acc;
            // (RULE15) right by zero or sixteen
            8'h5A: begin
              shAmt = shiftCountRegister[4] ? 5'h10 : 5'h00;
              s_nxt.acc = shOut;
            end
            // (RULE16) right by count
            8'h5B: begin
              shAmt = {1'b0, shiftCountRegister[3:0]};
              s_nxt.acc = shOut;
            end
            default: s_nxt.acc = s_r.acc;
          endcase
        end
      end
      default: s_nxt.st = ACD_FETCH;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // (RULE24) halves of the accumulator
  assign mainAccumulator = s_r.acc;
  assign accumulatorBuffer = s_r.bufWord;
  assign carryFlag = s_r.c;
  assign instrReady = s_r.rdy;
  assign dataAddr = s_r.addr;
  assign dataRead = s_r.rd;
  assign dataWrite = s_r.wr;
  assign dataOut = s_r.dout;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // (RULE5) magnitude clears carry
  a_mag_carry: assert property (@(posedge clk) disable iff (rst) // (RULE5)
    s_r.st == ACD_EXEC && s_r.op == 16'hBE00 |=> !carryFlag) else $error("carry not cleared");
  // (RULE14) invert result
  a_inv_result: assert property (@(posedge clk) disable iff (rst) // (RULE14)
    s_r.st == ACD_EXEC && s_r.op == 16'hBE01 |=> mainAccumulator == ~$past(s_r.acc)) else $error("bad invert");
  // (RULE18) swap result
  a_swap_pair: assert property (@(posedge clk) disable iff (rst) // (RULE18)
    s_r.st == ACD_EXEC && s_r.op == 16'hBE1D |=> accumulatorBuffer == $past(s_r.acc)) else $error("bad swap");
  // (RULE12) AND clears high
  a_and_high: assert property (@(posedge clk) disable iff (rst) // (RULE12)
    s_r.st == ACD_EXEC && s_r.op[15:8] == 8'h6E |=> mainAccumulator[31:16] == 16'h0000) else $error("high not clear");
  // (RULE20) low load clears high
  a_lowload_high: assert property (@(posedge clk) disable iff (rst) // (RULE20)
    s_r.st == ACD_EXEC && s_r.op[15:8] == 8'hB9 |=> mainAccumulator == {24'h00_0000, $past(s_r.op[7:0])})
    else $error("bad low load");
  // (RULE1) peripheral access waits
  a_periph_wait: assert property (@(posedge clk) disable iff (rst) // (RULE1)
    s_r.st == ACD_FETCH && s_r.rdy && instrValid && isMem && periph && !externalAccess
    && !pipeBlockBusy && instrWord[15:8] != 8'hBF |=> s_r.st == ACD_WAIT ##1 s_r.st == ACD_EXEC)
    else $error("no peripheral wait");
  // (RULE3) turnaround write three cycles
  a_turn_write: assert property (@(posedge clk) disable iff (rst) // (RULE3)
    s_r.st == ACD_FETCH && s_r.rdy && instrValid && isMem && isWrite && externalAccess && s_r.lastExtRead
    && !pipeBlockBusy |=> s_r.wait_ == 3'h2) else $error("no turnaround");
  // (RULE9) buffer add
  a_buf_add: assert property (@(posedge clk) disable iff (rst) // (RULE9)
    s_r.st == ACD_EXEC && s_r.op == 16'hBE10 |=> mainAccumulator == 32'($past(s_r.acc) + $past(s_r.bufWord)))
    else $error("bad buffer add");
endmodule : acd_decoder

/* verif/acd_data_mem.sv */
// data memory model facing the accumulator decoder
`timescale 1ns/1ps
module acd_data_mem (
  input wire logic clk,
  input wire logic [15:0] dataAddr,
  input wire logic dataRead,
  input wire logic dataWrite,
  input wire logic [15:0] dataOut,
  output logic [15:0] dataIn
);
  logic [15:0] mem [0:255];
  logic [15:0] heldAddr_r;
  logic held_r = 1'b0;
  logic [15:0] lastVal_r = 16'h0000;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // word picked by address
  always @(posedge clk) begin
    if (dataWrite) begin
      mem[dataAddr[7:0]] <= dataOut;
    end
    if (dataRead) begin
      heldAddr_r <= dataAddr;
      held_r <= 1'b1;
      lastVal_r <= mem[dataAddr[7:0]];
    end else if (dataAddr != heldAddr_r) begin
      held_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read bus
  // ----------------------------------------
  // released bus shows inverted last value
  always_comb begin
    if (dataRead || (held_r && dataAddr == heldAddr_r)) begin
      dataIn = mem[dataAddr[7:0]];
    end else begin
      dataIn = ~lastVal_r;
    end
  end
endmodule : acd_data_mem

/* verif/test_accumulator_instruction_decoder.sv */
// self-checking bench for the accumulator decoder
`timescale 1ns/1ps
module test_accumulator_instruction_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [15:0] dataIn;
  logic [15:0] dataPage = 16'h0000;
  logic [15:0] auxAddr = 16'h0000;
  logic [4:0] shiftCountRegister = 5'h00;
  logic signExtMode = 1'b1;
  logic externalAccess = 1'b0;
  logic pipeBlockBusy = 1'b0;
  logic [15:0] pipeBlockAddr = 16'hF800;
  logic instrReady, dataRead, dataWrite, carryFlag;
  logic [15:0] dataAddr, dataOut;
  logic [31:0] mainAccumulator, accumulatorBuffer;
  int failures = 0;
  int checked = 0;
  int lastCycles = 0;

  acd_decoder acd_decoder_inst (.clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
    .dataIn(dataIn), .dataPage(dataPage), .auxAddr(auxAddr), .shiftCountRegister(shiftCountRegister),
    .signExtMode(signExtMode), .externalAccess(externalAccess), .pipeBlockBusy(pipeBlockBusy),
    .pipeBlockAddr(pipeBlockAddr), .instrReady(instrReady), .dataAddr(dataAddr), .dataRead(dataRead),
    .dataWrite(dataWrite), .dataOut(dataOut), .mainAccumulator(mainAccumulator),
    .accumulatorBuffer(accumulatorBuffer), .carryFlag(carryFlag));

  acd_data_mem acd_data_mem_inst (.clk(clk), .dataAddr(dataAddr), .dataRead(dataRead),
    .dataWrite(dataWrite), .dataOut(dataOut), .dataIn(dataIn));

  initial begin
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic waitReady;
    int k;
    k = 0;
    while (instrReady !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    lastCycles = k;
    if (k >= 40) begin
      failures++;
      $display("wrong value instrReady expected 1 seen timeout");
      final_report();
    end
  endtask : waitReady

  task automatic issue(input logic [15:0] w);
    waitReady();
    instrValid = 1'b1;
    instrWord = w;
    @(posedge clk);
    #1;
    instrValid = 1'b0;
    waitReady();
    if (lastCycles == 0) begin
      @(posedge clk);
      #1;
    end
  endtask : issue

  task automatic opx(input logic [15:0] w, input logic [31:0] expAcc);
    issue(w);
    check("accumulator", mainAccumulator, expAcc);
  endtask : opx

  task automatic cyc(input logic [15:0] w, input int extra);
    issue(w);
    check("cycles", 32'(lastCycles), 32'(1 + extra));
  endtask : cyc

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_arith;
    acd_data_mem_inst.mem[8'h10] = 16'h8001;
    acd_data_mem_inst.mem[8'h11] = 16'h8000;
    acd_data_mem_inst.mem[8'h13] = 16'h0002;
    shiftCountRegister = 5'h04;
    opx(16'h1410, 32'hFFF8_0010);
    opx(16'hB805, 32'hFFF8_0015);
    opx(16'h6211, 32'hFFF8_8015);
    opx(16'h2311, 32'hFFF4_8015);
    check("carry", 32'(carryFlag), 32'h0000_0001);
    opx(16'h6011, 32'hFFF5_0016);
    opx(16'h6113, 32'hFFF7_0016);
    issue(16'hBF84);
    opx(16'h0123, 32'h0000_1230);
    issue(16'hBF90);
    opx(16'h0001, 32'h0000_1231);
    opx(16'h6311, 32'hFFF8_1231);
    opx(16'h6B11, 32'hFFF8_0000);
    opx(16'h2311, 32'hFFF4_0000);
    opx(16'hBE00, 32'h000C_0000);
    check("carry", 32'(carryFlag), 32'h0000_0000);
    opx(16'hBE02, 32'hFFF4_0000);
    opx(16'hBE01, 32'h000B_FFFF);
    $display("test arith done");
  endtask : t_arith

  task automatic t_logic;
    acd_data_mem_inst.mem[8'h12] = 16'h0F0F;
    opx(16'hB9AA, 32'h0000_00AA);
    opx(16'h6A12, 32'h0F0F_0000);
    opx(16'h6D12, 32'h0F0F_0F0F);
    opx(16'h6E12, 32'h0000_0F0F);
    issue(16'hBE82);
    opx(16'h00F0, 32'h00F0_0F0F);
    issue(16'hBE81);
    opx(16'h0030, 32'h0030_0000);
    issue(16'hBFC4);
    opx(16'h0F00, 32'h0030_F000);
    issue(16'hBFB0);
    opx(16'hFFFF, 32'h0000_F000);
    $display("test logic done");
  endtask : t_logic

  task automatic t_buffer;
    opx(16'hBE1F, 32'h0000_F000);
    check("buffer", accumulatorBuffer, 32'h0000_F000);
    opx(16'hB801, 32'h0000_F001);
    opx(16'hBE10, 32'h0001_E001);
    opx(16'hBE1B, 32'h0001_E001);
    check("buffer", accumulatorBuffer, 32'h0001_E001);
    opx(16'hB801, 32'h0001_E002);
    opx(16'hBE1D, 32'h0001_E001);
    check("buffer", accumulatorBuffer, 32'h0001_E002);
    opx(16'hBE1C, 32'h0001_E001);
    check("buffer", accumulatorBuffer, 32'h0001_E001);
    opx(16'hBE00, 32'h0001_E001);
    opx(16'hBE11, 32'h0003_C002);
    opx(16'hBE1E, 32'h0003_C002);
    check("buffer", accumulatorBuffer, 32'h0003_C002);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_shift;
    issue(16'hBF8C);
    opx(16'h4321, 32'h0432_1000);
    opx(16'hBE09, 32'h0864_2000);
    opx(16'hBE0A, 32'h0432_1000);
    opx(16'hBE0C, 32'h0864_2000);
    opx(16'hBE0D, 32'h0432_1000);
    opx(16'hBE16, 32'h0864_2000);
    check("buffer", accumulatorBuffer, 32'h0007_8004);
    opx(16'hBE17, 32'h0432_1000);
    check("buffer", accumulatorBuffer, 32'h0003_C002);
    opx(16'hBE14, 32'h0864_2000);
    check("buffer", accumulatorBuffer, 32'h0007_8004);
    opx(16'hBE15, 32'h0432_1000);
    shiftCountRegister = 5'h10;
    opx(16'hBE5A, 32'h0000_0432);
    shiftCountRegister = 5'h04;
    opx(16'hBE5B, 32'h0000_0043);
    opx(16'hBFE4, 32'h0000_0004);
    $display("test shift done");
  endtask : t_shift

  task automatic t_timing;
    acd_data_mem_inst.mem[8'h20] = 16'hABCD;
    acd_data_mem_inst.mem[8'h50] = 16'h1357;
    acd_data_mem_inst.mem[8'h15] = 16'h0042;
    cyc(16'h0820, 1);
    check("accumulator", mainAccumulator, 32'h0000_ABCD);
    cyc(16'h0850, 0);
    cyc(16'h8820, 1);
    check("memory", 32'(acd_data_mem_inst.mem[8'h20]), 32'h0000_1357);
    externalAccess = 1'b1;
    cyc(16'h9013, 1);
    check("memory", 32'(acd_data_mem_inst.mem[8'h13]), 32'h0000_1357);
    cyc(16'h1013, 0);
    cyc(16'h9C14, 2);
    check("memory", 32'(acd_data_mem_inst.mem[8'h14]), 32'h0000_0001);
    check("store data", 32'(dataOut), 32'h0000_0001);
    externalAccess = 1'b0;
    pipeBlockBusy = 1'b1;
    pipeBlockAddr = 16'h0000;
    cyc(16'h1013, 1);
    pipeBlockAddr = 16'h0800;
    cyc(16'h1013, 0);
    pipeBlockBusy = 1'b0;
    auxAddr = 16'h0015;
    opx(16'h1080, 32'h0000_0042);
    check("address", 32'(dataAddr), 32'h0000_0015);
    $display("test timing done");
  endtask : t_timing

  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_arith();
    t_logic();
    t_buffer();
    t_shift();
    t_timing();
    final_report();
  end
endmodule : test_accumulator_instruction_decoder
